// file: rtl/ticm_ctrl.sv
// Purpose: Two-mode interrupt controller with priority arbitration, vector table and AXI4-Lite registers
// Assumes: Sources and CPU signals are on sys_clk; the non-maskable pin is asynchronous
// Notes:   The CPU samples accept_* and answers with cpu_ack once its instruction ends
//
// What this block and the CPU core do
// RL1 - Each vector entry holds the low 16 bits of the handler start address.
// RL2 - Exactly two modes, 0 and 2, chosen in the mode control register.
// RL3 - Mode 0 uses fixed default order, ignores levels; global mask spares NMI.
// RL4 - Mode 2 gives each maskable source one of 8 levels; NMI outside.
// RL5 - Mode 2 masks in 8 levels using the CPU 3-bit mask level.
// RL6 - A source requests only while its enable bit is 1.
// RL7 - Mode 0 with global mask set accepts only NMI; others stay pending.
// RL8 - Mode 0 accepts the highest default-ranked request; others stay pending.
// RL9 - The CPU starts handling only after its current instruction completes.
// RL10 - Mode 0 CPU stacks counter and condition codes, counter resumes next instruction.
// RL11 - Mode 0 CPU sets the global mask bit after saving state.
// RL12 - Controller supplies the vector; the CPU jumps to the address held there.
// RL13 - Mode 2 picks highest level; equal levels fall back to default order.
// RL14 - Mode 2 accepts only a level strictly above the current mask level.
// RL15 - Mode 2 CPU stacks counter, condition codes and extended control register.
// RL16 - Mode 2 CPU clears trace bit and loads mask level with accepted level.
// RL17 - Mode 2 CPU loads mask level 7 when NMI is accepted.
// RL18 - Pending requests stay until cleared (NMI also drops on acceptance), re-evaluated every cycle.
`timescale 1ns/1ps
`default_nettype none
`include "ticm_defs.svh"
module ticm_ctrl
    import ticm_pkg::*;
#(
    parameter int NSRC       = 8,
    parameter int ADDR_W     = 8,
    parameter int VEC_BASE   = 64,
    parameter int NMI_VECNUM = 7
) (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                arst_n,
    // AXI4-Lite write address and data
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // Interrupt sources
    input  wire logic [NSRC-1:0]     src_event,
    input  wire logic                nmi_pin,
    // CPU core mask state and acknowledge
    input  wire logic                cpu_gmask,
    input  wire logic [2:0]          cpu_mask_level,
    input  wire logic                cpu_ack,
    // Acceptance towards the CPU core
    output logic                     accept_valid,
    output logic                     accept_nmi,
    output logic [2:0]               accept_level,
    output logic [$clog2(NSRC+1)-1:0] accept_idx,
    output logic [15:0]              accept_vec_addr,
    output logic [15:0]              handler_addr,
    // Summary interrupt
    output logic                     irq
);
    localparam int IW = $clog2(NSRC + 1);

    ticm_mode_t             mode;
    logic [NSRC-1:0]        en;
    logic [NSRC-1:0]        pend;
    logic                   nmi_pend;
    logic [NSRC*3-1:0]      prio;
    logic [15:0]            vtab [0:NSRC];
    logic                   aw_held;
    logic                   w_held;
    logic [ADDR_W-1:0]      aw_addr;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   nmi_meta;
    logic                   nmi_sync;
    logic                   nmi_last;
    logic                   do_write;
    logic [ADDR_W-1:0]      wa;
    logic [ADDR_W-1:0]      ra;
    logic [31:0]            wm;
    logic [31:0]            wd;
    logic                   sel_mode;
    logic                   sel_en;
    logic                   sel_stat;
    logic                   sel_prio;
    logic                   sel_acc;
    logic [NSRC:0]          sel_vec;
    logic                   wr_ok;
    logic [NSRC-1:0]        pend_clr;
    logic                   nmi_clr;
    logic                   tab_we;
    logic [31:0]            rd_val;
    logic                   rd_ok;

    ticm_arb_if #(.NSRC(NSRC), .IW(IW)) arb_bus ();

    ticm_arbiter #(.NSRC(NSRC)) u_arb (
        .bus (arb_bus.arb)
    );

    assign arb_bus.req   = pend & en;                            // [RL6]
    assign arb_bus.lvl   = prio;                                 // [RL4]
    assign arb_bus.mode  = mode;
    assign arb_bus.gmask = cpu_gmask;                            // [RL7]
    assign arb_bus.mlvl  = cpu_mask_level;                       // [RL5]
    assign arb_bus.nmi   = nmi_pend;

    // Write decode on the held address
    assign do_write = aw_held && w_held;
    assign wa = {aw_addr[ADDR_W-1:2], 2'b00};
    assign wm = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    assign wd = w_data & wm;

    always_comb begin
        sel_mode = do_write && (wa == ADDR_W'(`TICM_OFF_MODE));
        sel_en   = do_write && (wa == ADDR_W'(`TICM_OFF_ENABLE));
        sel_stat = do_write && (wa == ADDR_W'(`TICM_OFF_STATUS));
        sel_prio = do_write && (wa == ADDR_W'(`TICM_OFF_PRIO));
        sel_acc  = do_write && (wa == ADDR_W'(`TICM_OFF_ACCEPT));
        for (int k = 0; k <= NSRC; k++) begin
            sel_vec[k] = do_write && (wa == ADDR_W'(`TICM_OFF_VEC + 4 * k));
        end
    end

    assign wr_ok    = sel_mode || sel_en || sel_stat || sel_prio || sel_acc || (|sel_vec);
    assign pend_clr = sel_stat ? wd[NSRC-1:0] : '0;
    assign nmi_clr  = (sel_stat && wd[NSRC]) || (cpu_ack && accept_valid && accept_nmi);
    assign tab_we   = |sel_vec;

    // AXI write channels: address and data taken in either order, one write at a time
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TICM_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `TICM_RESP_OKAY : `TICM_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read mux; unmapped words answer zero with an error
    assign ra = {s_axi_araddr[ADDR_W-1:2], 2'b00};

    always_comb begin
        rd_val = 32'h0;
        rd_ok = 1'b1;
        if (ra == ADDR_W'(`TICM_OFF_MODE)) begin
            rd_val[1:0] = mode;
        end else if (ra == ADDR_W'(`TICM_OFF_ENABLE)) begin
            rd_val[NSRC-1:0] = en;
        end else if (ra == ADDR_W'(`TICM_OFF_STATUS)) begin
            rd_val[NSRC:0] = {nmi_pend, pend};
        end else if (ra == ADDR_W'(`TICM_OFF_PRIO)) begin
            rd_val[NSRC*3-1:0] = prio;
        end else if (ra == ADDR_W'(`TICM_OFF_ACCEPT)) begin
            rd_val[`TICM_ACC_VALID] = accept_valid;
            rd_val[`TICM_ACC_NMI] = accept_nmi;
            rd_val[`TICM_ACC_LVL +: 3] = accept_level;
            rd_val[`TICM_ACC_IDX +: IW] = accept_idx;
        end else begin
            rd_ok = 1'b0;
            for (int k = 0; k <= NSRC; k++) begin
                if (ra == ADDR_W'(`TICM_OFF_VEC + 4 * k)) begin
                    rd_val[15:0] = vtab[k];
                    rd_ok = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `TICM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? `TICM_RESP_OKAY : `TICM_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Mode field: codes other than the two legal ones are dropped
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode <= ticm_mode_t'(`TICM_RST_MODE);
        end else if (sel_mode && w_strb[0]) begin
            if (w_data[1:0] == TICM_MODE0 || w_data[1:0] == TICM_MODE2) begin  // [RL2]
                mode <= ticm_mode_t'(w_data[1:0]);
            end
        end
    end

    // Enables and priority levels
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            en <= '0;
            prio <= {NSRC{`TICM_RST_LEVEL}};
        end else begin
            if (sel_en) begin
                en <= (en & ~wm[NSRC-1:0]) | wd[NSRC-1:0];            // [RL6]
            end
            if (sel_prio) begin
                prio <= (prio & ~wm[NSRC*3-1:0]) | wd[NSRC*3-1:0];    // [RL4]
            end
        end
    end

    // Sticky pending flags; a new event beats a clear in the same cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend <= '0;
        end else begin
            pend <= (pend & ~pend_clr) | src_event;                   // [RL18]
        end
    end

    // Pin synchroniser, then rising-edge capture of the non-maskable request
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            nmi_meta <= 1'b0;
            nmi_sync <= 1'b0;
            nmi_last <= 1'b0;
            nmi_pend <= 1'b0;
        end else begin
            nmi_meta <= nmi_pin;
            nmi_sync <= nmi_meta;
            nmi_last <= nmi_sync;
            if (nmi_sync && !nmi_last) begin
                nmi_pend <= 1'b1;
            end else if (nmi_clr) begin
                nmi_pend <= 1'b0;                                      // [RL18]
            end
        end
    end

    // Vector table: low 16 bits of each handler start address
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int k = 0; k <= NSRC; k++) begin
                vtab[k] <= `TICM_RST_VECTOR;
            end
        end else begin
            for (int k = 0; k <= NSRC; k++) begin
                if (sel_vec[k]) begin
                    vtab[k] <= (vtab[k] & ~wm[15:0]) | wd[15:0];       // [RL1]
                end
            end
        end
    end

    // Acceptance is recomputed every cycle from the live mask state
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            accept_valid <= 1'b0;
            accept_nmi <= 1'b0;
            accept_level <= 3'h0;
            accept_idx <= '0;
            accept_vec_addr <= 16'h0000;
            handler_addr <= 16'h0000;
        end else begin
            accept_valid <= arb_bus.win_valid;                          // [RL18]
            accept_nmi <= arb_bus.win_nmi;
            accept_level <= arb_bus.win_lvl;
            accept_idx <= arb_bus.win_idx;
            accept_vec_addr <= arb_bus.win_nmi ? 16'(NMI_VECNUM * 4)
                               : 16'((VEC_BASE + int'(arb_bus.win_idx)) * 4);  // [RL12]
            handler_addr <= vtab[arb_bus.win_idx];                      // [RL1]
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= (|(pend & en)) || nmi_pend;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_mode0_open;
        mode == TICM_MODE0 && !cpu_gmask && !nmi_pend;
    endsequence
    sequence s_pend_stay;
        pend[0] && !pend_clr[0];
    endsequence

    property p_mode_legal;
        mode == TICM_MODE0 || mode == TICM_MODE2;
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("illegal mode code"); // [RL2]

    property p_table_fetch;
        accept_valid && !$past(tab_we) |-> handler_addr == vtab[accept_idx];
    endproperty
    a_table_fetch: assert property (p_table_fetch) else $error("handler address not from table"); // [RL1]

    property p_nmi_vector;
        accept_valid && accept_nmi |-> accept_vec_addr == 16'(NMI_VECNUM * 4);
    endproperty
    a_nmi_vector: assert property (p_nmi_vector) else $error("wrong nmi vector"); // [RL12]

    property p_mode0_ignore_lvl;
        s_mode0_open ##0 (arb_bus.req != '0) |=> accept_valid && !accept_nmi && accept_level == 3'h0;
    endproperty
    a_mode0_ignore_lvl: assert property (p_mode0_ignore_lvl) else $error("mode 0 used levels"); // [RL3]

    property p_mode0_masked;
        mode == TICM_MODE0 && cpu_gmask && !nmi_pend |=> !accept_valid;
    endproperty
    a_mode0_masked: assert property (p_mode0_masked) else $error("masked request accepted"); // [RL7]

    property p_default_order;
        s_mode0_open ##0 arb_bus.req[0] |=> accept_idx == '0;
    endproperty
    a_default_order: assert property (p_default_order) else $error("default order broken"); // [RL8]

    property p_nmi_wins;
        nmi_pend |=> accept_valid && accept_nmi && accept_level == `TICM_NMI_LEVEL;
    endproperty
    a_nmi_wins: assert property (p_nmi_wins) else $error("nmi not taken"); // [RL4]

    property p_mode2_above;
        mode == TICM_MODE2 && !nmi_pend |=> !accept_valid || accept_level > $past(cpu_mask_level);
    endproperty
    a_mode2_above: assert property (p_mode2_above) else $error("level not above mask"); // [RL14]

    property p_mode2_top_mask;
        mode == TICM_MODE2 && !nmi_pend && cpu_mask_level == 3'h7 |=> !accept_valid;
    endproperty
    a_mode2_top_mask: assert property (p_mode2_top_mask) else $error("mask level 7 leaked"); // [RL5]

    property p_mode2_pick;
        mode == TICM_MODE2 && !nmi_pend && arb_bus.req[1] && prio[5:3] > cpu_mask_level
            |=> accept_valid && accept_level >= $past(prio[5:3]);
    endproperty
    a_mode2_pick: assert property (p_mode2_pick) else $error("highest level not picked"); // [RL13]

    property p_enable_gate;
        arb_bus.req == '0 && !nmi_pend |=> !accept_valid;
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("request without enable"); // [RL6]

    property p_pend_held;
        s_pend_stay |=> pend[0];
    endproperty
    a_pend_held: assert property (p_pend_held) else $error("pending flag lost"); // [RL18]
endmodule // ticm_ctrl
`default_nettype wire

// file: rtl/ticm_defs.svh
// Purpose: Offsets, field positions and reset values of the interrupt mode controller
// Assumes: Byte addresses on a 32-bit register bus, one aligned word per register
// Notes:   Definitions only
`ifndef TICM_DEFS_SVH
`define TICM_DEFS_SVH

// Register byte offsets
`define TICM_OFF_MODE    32'h00
`define TICM_OFF_ENABLE  32'h04
`define TICM_OFF_STATUS  32'h08
`define TICM_OFF_PRIO    32'h0c
`define TICM_OFF_ACCEPT  32'h10
`define TICM_OFF_VEC     32'h40

// Accept register field positions
`define TICM_ACC_IDX     0
`define TICM_ACC_LVL     8
`define TICM_ACC_NMI     30
`define TICM_ACC_VALID   31

// Reset values and fixed levels
`define TICM_RST_MODE    2'h0
`define TICM_RST_LEVEL   3'h0
`define TICM_NMI_LEVEL   3'h7
`define TICM_RST_VECTOR  16'h0000

// Bus responses
`define TICM_RESP_OKAY   2'h0
`define TICM_RESP_SLVERR 2'h2

`endif

// file: rtl/ticm_pkg.sv
// Purpose: Types shared by the interrupt mode controller modules
// Assumes: Nothing beyond the header of constants
// Notes:   Only the two legal mode codes exist in the type
package ticm_pkg;
    typedef enum logic [1:0] {
        TICM_MODE0 = 2'h0,
        TICM_MODE2 = 2'h2
    } ticm_mode_t;
endpackage

// file: rtl/ticm_arb_if.sv
// Purpose: Carries requests, mask state and the arbitration result between controller and arbiter
// Assumes: One clock domain, combinational result
// Notes:   lvl packs three bits per source, source 0 in the low bits
`timescale 1ns/1ps
`default_nettype none
interface ticm_arb_if #(
    parameter int NSRC = 8,
    parameter int IW   = 4
);
    logic [NSRC-1:0]        req;
    logic [NSRC*3-1:0]      lvl;
    ticm_pkg::ticm_mode_t   mode;
    logic                   gmask;
    logic [2:0]             mlvl;
    logic                   nmi;
    logic                   win_valid;
    logic                   win_nmi;
    logic [IW-1:0]          win_idx;
    logic [2:0]             win_lvl;

    modport ctrl (output req, lvl, mode, gmask, mlvl, nmi, input win_valid, win_nmi, win_idx, win_lvl);
    modport arb  (input req, lvl, mode, gmask, mlvl, nmi, output win_valid, win_nmi, win_idx, win_lvl);
endinterface
`default_nettype wire

// file: rtl/ticm_arbiter.sv
// Purpose: Picks the one request that may be accepted in the current cycle
// Assumes: Requests are already gated by their enables
// Notes:   Lower source index ranks higher in the default order
`timescale 1ns/1ps
`default_nettype none
`include "ticm_defs.svh"
module ticm_arbiter
    import ticm_pkg::*;
#(
    parameter int NSRC = 8
) (
    // Request and result bundle
    ticm_arb_if.arb bus
);
    localparam int IW = $clog2(NSRC + 1);

    logic       found;
    logic [2:0] best;

    always_comb begin
        found = 1'b0;
        best = 3'h0;
        bus.win_valid = 1'b0;
        bus.win_nmi = 1'b0;
        bus.win_idx = '0;
        bus.win_lvl = 3'h0;
        if (bus.nmi) begin
            // Non-maskable source bypasses every mask and level
            bus.win_valid = 1'b1;
            bus.win_nmi = 1'b1;                                       // [RL4]
            bus.win_idx = IW'(NSRC);
            bus.win_lvl = `TICM_NMI_LEVEL;
        end else begin
            // Ascending scan with strict compare keeps the default order on ties
            for (int i = 0; i < NSRC; i++) begin
                if (bus.req[i] && (!found || (bus.mode == TICM_MODE2 && bus.lvl[i*3 +: 3] > best))) begin
                    found = 1'b1;
                    best = (bus.mode == TICM_MODE2) ? bus.lvl[i*3 +: 3] : 3'h0;  // [RL3] [RL13]
                    bus.win_idx = IW'(i);                             // [RL8]
                end
            end
            if (bus.mode == TICM_MODE0) begin
                bus.win_valid = found && !bus.gmask;                  // [RL7]
            end else begin
                bus.win_valid = found && (best > bus.mlvl);           // [RL14] [RL5]
                bus.win_lvl = best;
            end
        end
    end
endmodule // ticm_arbiter
`default_nettype wire

// file: bench/ticm_cpu_model.sv
// Purpose: Behavioural CPU core that takes acceptances from the controller
// Assumes: One clock; ld stands for a return from the handler
// Notes:   Stack contents are not kept, only the depth of pushes
`timescale 1ns/1ps
`default_nettype none
module ticm_cpu_model
    import ticm_pkg::*;
#(
    parameter int INSN = 2
) (
    // Clock, reset and mode
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire ticm_mode_t  mode,
    // Handler return with the restored mask state
    input  wire logic        ld,
    input  wire logic        ld_gmask,
    input  wire logic [2:0]  ld_lvl,
    // Offer from the controller
    input  wire logic        accept_valid,
    input  wire logic        accept_nmi,
    input  wire logic [2:0]  accept_level,
    input  wire logic [15:0] handler_addr,
    // Core state
    output logic             cpu_gmask,
    output logic [2:0]       cpu_mask_level,
    output logic             cpu_ack,
    output logic             trace,
    output logic [15:0]      pc,
    output logic [3:0]       sp
);
    logic busy;
    int   cnt;
    // No nesting: one handler at a time until ld returns from it
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            {cpu_gmask, cpu_mask_level, cpu_ack, busy, pc, sp} <= '0;
            trace <= 1'b1;
            cnt <= 0;
        end else begin
            cpu_ack <= 1'b0;
            if (ld) begin
                busy <= 1'b0;
                cpu_gmask <= ld_gmask;
                cpu_mask_level <= ld_lvl;
                trace <= 1'b1;
            end else if (busy || !accept_valid) begin
                cnt <= 0;
            end else if (cnt < INSN) begin
                cnt <= cnt + 1;
            end else begin
                busy <= 1'b1;
                cpu_ack <= 1'b1;
                pc <= handler_addr;
                if (mode == TICM_MODE2) begin
                    sp <= sp + 4'h3;
                    trace <= 1'b0;
                    cpu_mask_level <= accept_nmi ? 3'h7 : accept_level;
                end else begin
                    sp <= sp + 4'h2;
                    cpu_gmask <= 1'b1;
                end
            end
        end
    end
endmodule // ticm_cpu_model
`default_nettype wire

// file: bench/tb_two_mode_interrupt_priority_mask.sv
// Purpose: Self-checking bench for the two-mode interrupt controller
// Assumes: CPU core model answers offers after a short instruction
// Notes:   Vector entries hold distinct marks so each handler jump shows
`timescale 1ns/1ps
`default_nettype none
module tb_two_mode_interrupt_priority_mask;
    import ticm_pkg::*;
    localparam int VB = 64;
    localparam int NV = 7;
    logic        sys_clk = 0, arst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0]  awaddr = 0, araddr = 0, src_event = 0;
    logic [31:0] wdata = 0, rdata;
    logic        awready, wready, bvalid, arready, rvalid, gmask, ack, av, anmi, irq, trace;
    logic [1:0]  bresp, rresp;
    logic        nmi_pin = 0, ld = 0, ld_gmask = 0;
    logic [2:0]  ld_lvl = 0, mlvl, alvl;
    logic [3:0]  aidx, sp;
    logic [15:0] avec, hnd, pc;
    ticm_mode_t  mode = TICM_MODE0;
    int          n_mismatch = 0, check_count = 0, cyc = 0;

    always #12.5 sys_clk = ~sys_clk;

    ticm_ctrl #(.VEC_BASE(VB), .NMI_VECNUM(NV)) ticm_ctrl_i (.sys_clk(sys_clk), .arst_n(arst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .src_event(src_event), .nmi_pin(nmi_pin), .cpu_gmask(gmask),
        .cpu_mask_level(mlvl), .cpu_ack(ack), .accept_valid(av), .accept_nmi(anmi), .accept_level(alvl),
        .accept_idx(aidx), .accept_vec_addr(avec), .handler_addr(hnd), .irq(irq));
    ticm_cpu_model ticm_cpu_model_i (.sys_clk(sys_clk), .arst_n(arst_n), .mode(mode), .ld(ld),
        .ld_gmask(ld_gmask), .ld_lvl(ld_lvl), .accept_valid(av), .accept_nmi(anmi), .accept_level(alvl),
        .handler_addr(hnd), .cpu_gmask(gmask), .cpu_mask_level(mlvl), .cpu_ack(ack), .trace(trace),
        .pc(pc), .sp(sp));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge sys_clk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(32'(rresp), 32'(er));
        if (er == 2'h0) chk(rdata, ed);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Pulse lands at one edge; the offer shows one edge later
    task automatic pulse(input logic [7:0] m);
        @(posedge sys_clk);
        src_event <= m;
        @(posedge sys_clk);
        src_event <= 8'h00;
        settle(1);
    endtask
    task automatic load(input logic g, input logic [2:0] l);
        @(posedge sys_clk);
        {ld, ld_gmask, ld_lvl} <= {1'b1, g, l};
        @(posedge sys_clk);
        ld <= 1'b0;
    endtask
    task automatic offer(input logic [3:0] i);
        chk(32'(av), 32'h1);
        chk(32'(aidx), 32'(i));
        chk(32'(avec), (i == 4'h8) ? 32'(NV * 4) : 32'((VB + i) * 4));
        chk(32'(hnd), 32'h0000a000 | 32'(i));
    endtask
    // The pin goes through a synchroniser, so the wait is open-ended
    task automatic nmi_offer;
        @(posedge sys_clk);
        nmi_pin <= 1'b1;
        do settle(1); while (anmi !== 1'b1);
        offer(4'h8);
        settle(6);
        nmi_pin <= 1'b0;
    endtask

    task automatic t_regs;
        wr(8'h00, 32'h1, 2'h0);
        rd(8'h00, 32'h0, 2'h0);
        wr(8'h20, 32'h1, 2'h2);
        rd(8'h20, 32'h0, 2'h2);
        for (int k = 0; k <= 8; k++) wr(8'(8'h40 + 4 * k), 32'h5a5aa000 + k, 2'h0);
        rd(8'h60, 32'h0000a008, 2'h0);
        $display("test regs done");
    endtask
    task automatic t_disabled;
        pulse(8'h80);
        settle(2);
        chk(32'(av), 32'h0);
        chk(32'(irq), 32'h0);
        wr(8'h08, 32'h1ff, 2'h0);
        $display("test disabled done");
    endtask
    task automatic t_mode2;
        mode <= TICM_MODE2;
        wr(8'h00, 32'h2, 2'h0);
        wr(8'h0c, 32'h00028428, 2'h0);
        wr(8'h04, 32'h2b, 2'h0);
        pulse(8'h2a);
        offer(4'h1);
        chk(32'(alvl), 32'h5);
        rd(8'h08, 32'h2a, 2'h0);
        settle(4);
        chk(32'(mlvl), 32'h5);
        chk({trace, pc, sp}, {1'b0, 16'ha001, 4'h3});
        chk(32'(av), 32'h0);
        load(1'b0, 3'h4);
        settle(2);
        chk(32'(av), 32'h1);
        settle(4);
        load(1'b0, 3'h5);
        nmi_offer;
        chk(32'(mlvl), 32'h7);
        $display("test mode2 done");
    endtask
    task automatic t_mode0;
        wr(8'h08, 32'h1ff, 2'h0);
        load(1'b0, 3'h0);
        settle(2);
        chk(32'(irq), 32'h0);
        mode <= TICM_MODE0;
        wr(8'h00, 32'h0, 2'h0);
        pulse(8'h29);
        offer(4'h0);
        settle(6);
        chk({gmask, pc, sp}, {1'b1, 16'ha000, 4'hb});
        chk(32'(av), 32'h0);
        chk(32'(irq), 32'h1);
        load(1'b1, 3'h0);
        settle(2);
        chk(32'(av), 32'h0);
        nmi_offer;
        chk(32'(pc), 32'ha008);
        $display("test mode0 done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_regs;
        t_disabled;
        t_mode2;
        t_mode0;
        tally_and_finish;
    end
endmodule // tb_two_mode_interrupt_priority_mask
`default_nettype wire
